/* async_timer.sv */
// Behaviour
// - selector picks stop, undivided, or prescaler tap
// - counter register readable live, writable live only in sync mode
// - counter write blocks next compare match
// - compare value continuously compared with counter
// - async select chooses oscillator tick source
// - counter write in async mode sets counter busy flag
// - compare write in async mode sets compare busy flag
// - control write in async mode sets control busy flag
// - counter read live, compare and control read holding
// - compare interrupt needs enable, global, flag
// - overflow interrupt needs enable, global, flag
// - compare flag set on match, cleared
// - overflow flag set on overflow, cleared
// - pwm mode sets overflow at bottom
// - prescaler reset bit self clears
// - prescaler reset reads one until done
// - data space address is offset plus 0x20
// - async flags reach cpu after sync delay
`timescale 1ns/100ps
`default_nettype none
`include "timer_regs.svh"
module async_timer (
    // clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       rst_in,
    input  wire logic       clk_en_in,
    // i/o register bus
    input  wire logic [6:0] io_addr_in,
    input  wire logic       io_data_space_in,
    input  wire logic       io_wr_in,
    input  wire logic       io_rd_in,
    input  wire logic [7:0] io_wdata_in,
    output logic      [7:0] io_rdata_out,
    // cpu status and vector acknowledges
    input  wire logic       global_int_in,
    input  wire logic       compare_vector_ack_in,
    input  wire logic       overflow_vector_ack_in,
    // timer oscillator input, sampled as a level
    input  wire logic       timer_oscillator_input_in,
    // interrupt requests and waveform
    output logic            compare_irq_out,
    output logic            overflow_irq_out,
    output logic            compare_match_out,
    output logic            waveform_output_pin_out
);
    // whole block state
    // kept as one packed word so reset and the clock enable treat every
    // field alike and nothing can be left out of the freeze
    typedef struct packed {
        logic [7:0] count;          // live counter
        logic [7:0] compare;        // active compare value
        logic [7:0] control;        // active control value
        logic [7:0] compare_hold;   // holding register, read back
        logic [7:0] control_hold;   // holding register, read back
        logic [7:0] count_hold;     // pending counter value
        logic [2:0] busy;           // counter, compare, control pending
        logic       async_sel;      // oscillator as tick source
        logic       compare_en;
        logic       overflow_en;
        logic       compare_flag;
        logic       overflow_flag;
        logic       psr_pending;    // prescaler reset in progress
        logic [9:0] prescale;       // prescaler counter
        logic       osc_d;          // previous oscillator level
        logic [1:0] sync_ctr;       // extra sync delay for async transfers
        logic       block_match;    // compare blocked for next tick
        logic       down;           // pwm down-counting
        logic       osc_tick_pend;  // oscillator edge transferred, awaiting busy clear
        logic [7:0] rdata;
        logic       cmp_irq;
        logic       ovf_irq;
        logic       match_o;
        logic       wave;
    } state_s;

    // one registered copy of all state; the next copy is built in one
    // combinational pass so every field has a single driver
    state_s r_r, r_nxt;

    // maps a bus address to an i/o offset; it does not flag unmapped addresses
    // data-space addresses sit 0x20 above their i/o addresses
    // range checking is left to the caller, which knows the space in use
    function automatic logic [6:0] io_offset(input logic [6:0] a, input logic ds);
        io_offset = ds ? a - `DATA_SPACE_OFFSET : a;
    endfunction

    // true when the selected tap fires on this prescaler count
    // taps fire when the low prescaler bits are all ones, so a prescaler
    // reset gives the full period before the first tick
    // every code is legal, so the case needs no default
    function automatic logic tap_hit(input logic [2:0] sel, input logic [9:0] p);
        unique case (timer_pkg::clock_selector_e'(sel))
            timer_pkg::CLK_STOP:    tap_hit = 1'b0;
            timer_pkg::CLK_DIV1:    tap_hit = 1'b1;
            timer_pkg::CLK_DIV8:    tap_hit = (p[2:0] == 3'h7);
            timer_pkg::CLK_DIV32:   tap_hit = (p[4:0] == 5'h1F);
            timer_pkg::CLK_DIV64:   tap_hit = (p[5:0] == 6'h3F);
            timer_pkg::CLK_DIV128:  tap_hit = (p[6:0] == 7'h7F);
            timer_pkg::CLK_DIV256:  tap_hit = (p[7:0] == 8'hFF);
            timer_pkg::CLK_DIV1024: tap_hit = (p == 10'h3FF);
        endcase
    endfunction

    // decoded bus fields and timer events, all rebuilt every cycle
    // by the next-state process below
    logic [6:0] ofs;
    logic       in_range;
    logic       src_tick;   // base tick, i/o clock or oscillator edge
    logic       tmr_tick;   // prescaled timer tick
    logic       pwm;
    logic       match;      // counter equals active compare value
    logic       cmp_set;    // hardware sets the compare flag this cycle
    logic       ovf_set;    // hardware sets the overflow flag this cycle

    // next-state logic
    // order matters: counting first, then holding-register transfers,
    // then flag clears, then cpu writes, so a cpu write has the last word
    // on the counter as the timer requires
    always_comb begin
        r_nxt    = r_r;
        ofs      = io_offset(io_addr_in, io_data_space_in);
        in_range = io_data_space_in ? (io_addr_in >= `DATA_SPACE_OFFSET) : (io_addr_in[6] == 1'b0);
        // set events start quiet; a set in this cycle beats a clear
        cmp_set  = 1'b0;
        ovf_set  = 1'b0;
        pwm      = r_r.control[`BIT_WGM0];
        // hazard: a slow crystal level must count once, so only the rising
        // edge seen against the stored level makes a tick
        // oscillator edge detect; input is treated as synchronous
        r_nxt.osc_d = timer_oscillator_input_in;
        src_tick = r_r.async_sel ? (timer_oscillator_input_in && !r_r.osc_d) : 1'b1;
        // the prescaler is shared by all taps, so switching taps does not
        // restart it; software uses the prescaler reset for a clean start
        // prescaler runs on the base tick
        if (src_tick) begin
            r_nxt.prescale = r_r.prescale + 10'h001;
        end
        tmr_tick = src_tick && tap_hit(r_r.control[2:0], r_r.prescale);
        if (r_r.psr_pending && src_tick) begin
            r_nxt.prescale    = 10'h000;
            r_nxt.psr_pending = 1'b0;
        end
        // the comparator looks at the active value, never the holding one,
        // so a pending async compare write cannot match early
        match = (r_r.count == r_r.compare);
        r_nxt.match_o = 1'b0;
        // a match raises the flag on the tick after the counter arrives,
        // and a just-written counter skips exactly one such tick
        // limitation: no clear-on-match mode, the counter wraps in normal mode and turns at 0xFF and 0x00 in pwm mode
        // counting, only on the timer tick
        if (tmr_tick) begin
            r_nxt.block_match = 1'b0;
            if (match && !r_r.block_match) begin
                r_nxt.compare_flag = 1'b1;
                cmp_set            = 1'b1;
                r_nxt.match_o      = 1'b1;
                r_nxt.wave         = ~r_r.wave;
            end
            if (pwm) begin
                if (!r_r.down && r_r.count == 8'hFF) begin
                    r_nxt.down  = 1'b1;
                    r_nxt.count = 8'hFE;
                end else if (r_r.down && r_r.count == 8'h00) begin
                    r_nxt.down          = 1'b0;
                    r_nxt.count         = 8'h01;
                    r_nxt.overflow_flag = 1'b1;
                    ovf_set             = 1'b1;
                end else begin
                    r_nxt.count = r_r.down ? r_r.count - 8'h01 : r_r.count + 8'h01;
                end
            end else begin
                r_nxt.count = r_r.count + 8'h01;
                if (r_r.count == 8'hFF) begin
                    r_nxt.overflow_flag = 1'b1;
                    ovf_set             = 1'b1;
                end
            end
        end
        // the oscillator is far slower than the i/o clock, so a value
        // written by the cpu waits here for the next crystal edge
        // all pending registers move together on that one edge
        // async transfer from holding registers on an oscillator edge
        if (r_r.async_sel && src_tick && |r_r.busy) begin
            r_nxt.osc_tick_pend = 1'b1;
            if (r_r.busy[2]) begin
                r_nxt.count       = r_r.count_hold;
                r_nxt.block_match = 1'b1;
            end
            if (r_r.busy[1]) r_nxt.compare = r_r.compare_hold;
            if (r_r.busy[0]) r_nxt.control = r_r.control_hold;
            r_nxt.sync_ctr = 2'h0;
        end
        // the busy bits are what software polls; clearing them early would
        // let a second write land on a transfer still in flight
        // trade-off: a fixed delay instead of a real two-flop handshake
        // busy clears after the sync delay into the i/o domain
        if (r_r.osc_tick_pend) begin
            r_nxt.sync_ctr = r_r.sync_ctr + 2'h1;
            if (r_r.sync_ctr == 2'(`SYNC_CYCLES - 1)) begin
                r_nxt.busy          = 3'h0;
                r_nxt.osc_tick_pend = 1'b0;
            end
        end
        // vector execution clears flags
        // a set in the same cycle wins over the vector acknowledge
        if (compare_vector_ack_in && !cmp_set)  r_nxt.compare_flag  = 1'b0;
        if (overflow_vector_ack_in && !ovf_set) r_nxt.overflow_flag = 1'b0;
        // writes while a busy bit is set are not refused; the cpu must poll
        // first, and a refused write would hide that software bug
        // the force strobe in control bit 7 is not kept, it reads as zero
        // register writes; counter write beats counting
        if (io_wr_in && in_range) begin
            unique case (ofs[5:0])
                `OFS_COUNT_VALUE: begin
                    if (r_r.async_sel) begin
                        r_nxt.count_hold = io_wdata_in;
                        r_nxt.busy[2]    = 1'b1;
                    end else begin
                        r_nxt.count       = io_wdata_in;
                        r_nxt.block_match = 1'b1;
                    end
                end
                `OFS_COMPARE_VALUE: begin
                    r_nxt.compare_hold = io_wdata_in;
                    if (r_r.async_sel) r_nxt.busy[1] = 1'b1;
                    else r_nxt.compare = io_wdata_in;
                end
                `OFS_TIMER_CONTROL: begin
                    r_nxt.control_hold = io_wdata_in & 8'h7F;
                    if (r_r.async_sel) r_nxt.busy[0] = 1'b1;
                    else r_nxt.control = io_wdata_in & 8'h7F;
                end
                `OFS_ASYNC_STATUS: r_nxt.async_sel = io_wdata_in[`BIT_ASYNC_SELECT];
                `OFS_INT_MASK: begin
                    r_nxt.compare_en  = io_wdata_in[`BIT_COMPARE_ENABLE];
                    r_nxt.overflow_en = io_wdata_in[`BIT_OVERFLOW_ENABLE];
                end
                `OFS_INT_FLAGS: begin
                    // write one clears, but a same-cycle set wins
                    if (io_wdata_in[`BIT_COMPARE_FLAG] && !cmp_set)
                        r_nxt.compare_flag = 1'b0;
                    if (io_wdata_in[`BIT_OVERFLOW_FLAG] && !ovf_set)
                        r_nxt.overflow_flag = 1'b0;
                end
                `OFS_SPECIAL_FUNC: begin
                    // in sync mode the reset is immediate, so the bit never reads one
                    if (io_wdata_in[`BIT_PRESCALER_RESET]) begin
                        if (r_r.async_sel) r_nxt.psr_pending = 1'b1;
                        else r_nxt.prescale = 10'h000;
                    end
                end
                default: ;
            endcase
        end
        // read data stands for exactly one cycle after the strobe and is
        // zero otherwise, so a bus mux outside may simply or the sources
        // counter reads see the live count, not the pending async value
        // registered read data; unmapped reads zero
        r_nxt.rdata = `RESET_BYTE;
        if (io_rd_in && in_range) begin
            unique case (ofs[5:0])
                `OFS_COUNT_VALUE:   r_nxt.rdata = r_r.count;
                `OFS_COMPARE_VALUE: r_nxt.rdata = r_r.compare_hold;
                `OFS_TIMER_CONTROL: r_nxt.rdata = r_r.control_hold;
                `OFS_ASYNC_STATUS:  r_nxt.rdata = {4'h0, r_r.async_sel, r_r.busy};
                `OFS_INT_MASK:      r_nxt.rdata = {r_r.compare_en, r_r.overflow_en, 6'h00};
                `OFS_INT_FLAGS:     r_nxt.rdata = {r_r.compare_flag, r_r.overflow_flag, 6'h00};
                `OFS_SPECIAL_FUNC:  r_nxt.rdata = {6'h00, r_r.psr_pending, 1'b0};
                default:            r_nxt.rdata = `RESET_BYTE;
            endcase
        end
        // built from the next flags so a request drops in the same cycle
        // as the flag clear, never one cycle late
        // interrupt requests from the settled flags
        r_nxt.cmp_irq = r_nxt.compare_en && global_int_in && r_nxt.compare_flag;
        r_nxt.ovf_irq = r_nxt.overflow_en && global_int_in && r_nxt.overflow_flag;
    end

    // reset loads only constants; all registers and flags come up zero
    // while the enable is low nothing moves, not even the edge detector,
    // so an oscillator edge during a freeze is seen once afterwards
    // state register; clock enable freezes everything
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            r_r <= '0;
        end else if (clk_en_in) begin
            r_r <= r_nxt;
        end
    end

    // no logic between the state flops and the pins, so the outputs
    // carry no glitches into the interrupt controller
    // outputs straight from flops
    assign io_rdata_out            = r_r.rdata;
    assign compare_irq_out         = r_r.cmp_irq;
    assign overflow_irq_out        = r_r.ovf_irq;
    assign compare_match_out       = r_r.match_o;
    assign waveform_output_pin_out = r_r.wave;
endmodule // async_timer
`default_nettype wire

/* timer_regs.svh */
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH
// register offsets in i/o space; data space adds the data offset
`define IO_SPACE_TOP       6'h3F
`define DATA_SPACE_OFFSET  7'h20
`define OFS_ASYNC_STATUS   6'h22
`define OFS_COMPARE_VALUE  6'h23
`define OFS_COUNT_VALUE    6'h24
`define OFS_TIMER_CONTROL  6'h25
`define OFS_SPECIAL_FUNC   6'h30
`define OFS_INT_FLAGS      6'h38
`define OFS_INT_MASK       6'h39
// field positions
`define BIT_ASYNC_SELECT   3
`define BIT_COUNTER_BUSY   2
`define BIT_COMPARE_BUSY   1
`define BIT_CONTROL_BUSY   0
`define BIT_COMPARE_ENABLE 7
`define BIT_OVERFLOW_ENABLE 6
`define BIT_COMPARE_FLAG   7
`define BIT_OVERFLOW_FLAG  6
`define BIT_PRESCALER_RESET 1
`define BIT_WGM0           6
`define BIT_WGM1           3
// reset values
`define RESET_BYTE         8'h00
// synchronisation depth into the i/o domain, in i/o cycles
`define SYNC_CYCLES        3
`endif

/* timer_pkg.sv */
package timer_pkg;
    // clock selector encodings
    typedef enum logic [2:0] {
        CLK_STOP = 3'h0, CLK_DIV1 = 3'h1, CLK_DIV8 = 3'h2, CLK_DIV32 = 3'h3,
        CLK_DIV64 = 3'h4, CLK_DIV128 = 3'h5, CLK_DIV256 = 3'h6, CLK_DIV1024 = 3'h7
    } clock_selector_e;
endpackage

/* async_timer_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module async_timer_sva (
    // clock and reset
    input wire logic       ref_clk_in,
    input wire logic       rst_in,
    // bus side seen by the timer
    input wire logic [6:0] io_addr_in,
    input wire logic       io_data_space_in,
    input wire logic       io_rd_in,
    input wire logic [7:0] io_rdata_out,
    input wire logic       global_int_in,
    // timer outputs
    input wire logic       compare_irq_out,
    input wire logic       overflow_irq_out,
    input wire logic       compare_match_out,
    input wire logic       waveform_output_pin_out
);
    // register offset, whichever space the address came in
    logic [6:0] ofs;
    assign ofs = io_data_space_in ? io_addr_in - 7'h20 : io_addr_in;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // read strobe aimed at one offset
    sequence s_rd(logic [6:0] o);
        io_rd_in && ofs == o;
    endsequence
    chk_cmp_irq_global: assert property (compare_irq_out |-> $past(global_int_in))
        else $error("compare request without global enable");
    chk_ovf_irq_global: assert property (overflow_irq_out |-> $past(global_int_in))
        else $error("overflow request without global enable");
    chk_rdata_idle_zero: assert property (!$past(io_rd_in) |-> io_rdata_out == 8'h00)
        else $error("read data not zero outside a read");
    chk_unmapped_read: assert property (io_rd_in && !(ofs inside {7'h22, 7'h23, 7'h24,
        7'h25, 7'h30, 7'h38, 7'h39}) |=> io_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    chk_match_pulse: assert property (compare_match_out |=> !compare_match_out)
        else $error("match pulse longer than one cycle");
    chk_wave_on_match: assert property ($changed(waveform_output_pin_out)
        |-> compare_match_out || $past(compare_match_out))
        else $error("waveform moved without a match");
    chk_status_spare: assert property (s_rd(7'h22) |=> io_rdata_out[7:4] == 4'h0)
        else $error("status spare bits set");
    chk_flag_spare: assert property (s_rd(7'h38) |=> io_rdata_out[5:0] == 6'h00)
        else $error("flag spare bits set");
    chk_mask_spare: assert property (s_rd(7'h39) |=> io_rdata_out[5:0] == 6'h00)
        else $error("mask spare bits set");
    chk_sfio_spare: assert property (s_rd(7'h30)
        |=> {io_rdata_out[7:2], io_rdata_out[0]} == 7'h00)
        else $error("special function spare bits set");
endmodule // async_timer_sva
bind async_timer async_timer_sva chk (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .io_addr_in(io_addr_in), .io_data_space_in(io_data_space_in), .io_rd_in(io_rd_in),
    .io_rdata_out(io_rdata_out), .global_int_in(global_int_in),
    .compare_irq_out(compare_irq_out), .overflow_irq_out(overflow_irq_out),
    .compare_match_out(compare_match_out), .waveform_output_pin_out(waveform_output_pin_out));
`default_nettype wire

/* cpu_model.sv */
`timescale 1ns/100ps
`default_nettype none
module cpu_model (
    // clock
    input wire logic       ref_clk_in,
    // register bus toward the timer
    output logic     [6:0] io_addr_out,
    output logic           io_data_space_out,
    output logic           io_wr_out,
    output logic           io_rd_out,
    output logic     [7:0] io_wdata_out,
    input wire logic [7:0] io_rdata_in
);
    // bus idle; strobes low from time zero
    initial begin
        {io_addr_out, io_data_space_out, io_wr_out, io_rd_out, io_wdata_out} = '0;
    end
    // one write strobe; idle lines show the inverse so stale data never matches
    task automatic wr(input logic [5:0] o, input logic [7:0] d, input logic ds);
        @(negedge ref_clk_in);
        io_addr_out = ds ? {1'b0, o} + 7'h20 : {1'b0, o};
        io_data_space_out = ds;
        io_wdata_out = d;
        io_wr_out = 1'b1;
        @(negedge ref_clk_in);
        io_wr_out = 1'b0;
        io_addr_out = ~io_addr_out;
        io_wdata_out = ~d;
    endtask
    // one read strobe; data lands one cycle after the strobe
    task automatic rd(input logic [5:0] o, input logic ds, output logic [7:0] d);
        @(negedge ref_clk_in);
        io_addr_out = ds ? {1'b0, o} + 7'h20 : {1'b0, o};
        io_data_space_out = ds;
        io_rd_out = 1'b1;
        @(negedge ref_clk_in);
        io_rd_out = 1'b0;
        io_addr_out = ~io_addr_out;
        d = io_rdata_in;
    endtask
endmodule // cpu_model
`default_nettype wire

/* async_timer_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "timer_regs.svh"
module async_timer_tb;
    logic       ref_clk_in;  // 50 mhz
    logic       rst_in;
    logic       global_int;  // cpu global enable
    logic       cmp_ack;     // compare vector taken
    logic       osc;         // crystal input, still outside async test
    logic [6:0] addr;
    logic       ds, wr, rd;
    logic [7:0] wdata, rdata;
    logic       cmp_irq, ovf_irq, match, wave;
    int         mismatches = 0;
    int         checks = 0;
    int         match_seen = 0; // compare match pulses seen
    // count match pulses away from the launching edge
    always @(negedge ref_clk_in) if (match === 1'b1) match_seen++;
    async_timer dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .clk_en_in(1'b1),
        .io_addr_in(addr), .io_data_space_in(ds), .io_wr_in(wr), .io_rd_in(rd),
        .io_wdata_in(wdata), .io_rdata_out(rdata), .global_int_in(global_int),
        .compare_vector_ack_in(cmp_ack), .overflow_vector_ack_in(1'b0),
        .timer_oscillator_input_in(osc), .compare_irq_out(cmp_irq),
        .overflow_irq_out(ovf_irq), .compare_match_out(match), .waveform_output_pin_out(wave));
    cpu_model cpu (.ref_clk_in(ref_clk_in), .io_addr_out(addr), .io_data_space_out(ds),
        .io_wr_out(wr), .io_rd_out(rd), .io_wdata_out(wdata), .io_rdata_in(rdata));
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // read a register and compare with the expected byte
    task automatic rdc(input logic [5:0] o, input logic [7:0] exp);
        logic [7:0] d;
        cpu.rd(o, 1'b0, d);
        cmp(d, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask
    // reset values, data-space alias, a hole in the map
    task automatic t_reset();
        logic [5:0] ofs [7] = '{`OFS_ASYNC_STATUS, `OFS_COMPARE_VALUE, `OFS_COUNT_VALUE,
            `OFS_TIMER_CONTROL, `OFS_SPECIAL_FUNC, `OFS_INT_FLAGS, `OFS_INT_MASK};
        foreach (ofs[i]) rdc(ofs[i], `RESET_BYTE);
        cpu.wr(`OFS_COMPARE_VALUE, 8'h5A, 1'b1);
        rdc(`OFS_COMPARE_VALUE, 8'h5A);
        rdc(6'h26, 8'h00);
        cpu.wr(`OFS_SPECIAL_FUNC, 8'h02, 1'b0);
        rdc(`OFS_SPECIAL_FUNC, 8'h00);
    endtask
    // every selector code: count after eight tap periods
    task automatic t_select();
        int div [8] = '{1, 1, 8, 32, 64, 128, 256, 1024};
        logic [7:0] d;
        for (int s = 0; s < 8; s++) begin
            cpu.wr(`OFS_TIMER_CONTROL, 8'h00, 1'b0);
            cpu.wr(`OFS_COUNT_VALUE, 8'h00, 1'b0);
            cpu.wr(`OFS_SPECIAL_FUNC, 8'h02, 1'b0);
            cpu.wr(`OFS_TIMER_CONTROL, {5'h00, 3'(s)}, 1'b0);
            tick(8 * div[s]);
            cpu.wr(`OFS_TIMER_CONTROL, 8'h00, 1'b0);
            cpu.rd(`OFS_COUNT_VALUE, 1'b0, d);
            if (s == 0) cmp(d, 8'h00);
            else cmp({7'h00, d >= 8'h07 && d <= 8'h0A}, 8'h01);
        end
    endtask
    // blocked match, flags, requests, both ways of clearing
    task automatic t_match();
        global_int = 1'b1;
        cpu.wr(`OFS_INT_MASK, 8'hC0, 1'b0);
        cpu.wr(`OFS_COMPARE_VALUE, 8'h20, 1'b0);
        cpu.wr(`OFS_COUNT_VALUE, 8'h20, 1'b0);
        cpu.wr(`OFS_INT_FLAGS, 8'hC0, 1'b0);
        cpu.wr(`OFS_TIMER_CONTROL, 8'h01, 1'b0);
        tick(100);
        rdc(`OFS_INT_FLAGS, 8'h00);
        cmp({7'h00, cmp_irq}, 8'h00);
        cmp(8'(match_seen), 8'h00);
        tick(256);
        rdc(`OFS_INT_FLAGS, 8'hC0);
        cmp(8'(match_seen), 8'h01);
        cmp({7'h00, wave}, 8'h01);
        cmp({6'h00, cmp_irq, ovf_irq}, 8'h03);
        global_int = 1'b0;
        cpu.wr(`OFS_TIMER_CONTROL, 8'h00, 1'b0);
        tick(2);
        cmp({6'h00, cmp_irq, ovf_irq}, 8'h00);
        cpu.wr(`OFS_INT_FLAGS, 8'h40, 1'b0);
        rdc(`OFS_INT_FLAGS, 8'h80);
        cmp_ack = 1'b1;
        tick(1);
        cmp_ack = 1'b0;
        rdc(`OFS_INT_FLAGS, 8'h00);
    endtask
    // pwm mode: overflow only when turning at the bottom
    task automatic t_pwm();
        logic [7:0] d;
        cpu.wr(`OFS_COUNT_VALUE, 8'hF0, 1'b0);
        cpu.wr(`OFS_INT_FLAGS, 8'hC0, 1'b0);
        cpu.wr(`OFS_TIMER_CONTROL, 8'h41, 1'b0);
        tick(40);
        cpu.rd(`OFS_INT_FLAGS, 1'b0, d);
        cmp({7'h00, d[6]}, 8'h00);
        tick(280);
        cpu.wr(`OFS_TIMER_CONTROL, 8'h00, 1'b0);
        cpu.rd(`OFS_INT_FLAGS, 1'b0, d);
        cmp({7'h00, d[6]}, 8'h01);
    endtask
    // crystal mode: busy flags until the oscillator moves the values
    task automatic t_async();
        cpu.wr(`OFS_ASYNC_STATUS, 8'h08, 1'b0);
        cpu.wr(`OFS_COUNT_VALUE, 8'h33, 1'b0);
        cpu.wr(`OFS_COMPARE_VALUE, 8'h11, 1'b0);
        cpu.wr(`OFS_TIMER_CONTROL, 8'h00, 1'b0);
        rdc(`OFS_ASYNC_STATUS, 8'h0F);
        cpu.wr(`OFS_SPECIAL_FUNC, 8'h02, 1'b0);
        rdc(`OFS_SPECIAL_FUNC, 8'h02);
        repeat (8) begin
            tick(8);
            osc = 1'b1;
            tick(8);
            osc = 1'b0;
        end
        tick(10);
        rdc(`OFS_ASYNC_STATUS, 8'h08);
        rdc(`OFS_COUNT_VALUE, 8'h33);
        rdc(`OFS_COMPARE_VALUE, 8'h11);
        rdc(`OFS_SPECIAL_FUNC, 8'h00);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // free-running reference clock
    initial begin
        ref_clk_in = 1'b0;
        forever #10 ref_clk_in = ~ref_clk_in;
    end
    // watchdog, well past the expected run of about thirteen thousand cycles
    initial begin
        #800000;
        mismatches++;
        test_done();
    end
    initial begin
        rst_in = 1'b1;
        global_int = 1'b0;
        cmp_ack = 1'b0;
        osc = 1'b0;
        tick(20);
        rst_in = 1'b0;
        t_reset();
        t_select();
        t_match();
        t_pwm();
        t_async();
        test_done();
    end
endmodule // async_timer_tb
`default_nettype wire
